// ==== verilog/puecs_pkg.sv ====
// Package: constants and carriers for the power controller event counters
package puecs_pkg;

    // Counter bank shape
    localparam int CTR_NUM = 4;
    localparam int CTR_W = 48;
    localparam int CODE_W = 8;
    localparam int OCC_W = 4;

    // Values after reset
    localparam logic [47:0] CTR_RESET = 48'h0;
    localparam logic [3:0] OCC_RESET = 4'h0;

    // Event codes
    localparam logic [7:0] EV_NONE = 8'h00;
    localparam logic [7:0] EV_CLOCKTICKS = 8'h01;
    localparam logic [7:0] EV_FREQ_THERMAL = 8'h04;
    localparam logic [7:0] EV_FREQ_POWER = 8'h05;
    localparam logic [7:0] EV_ALARM_INT = 8'h09;
    localparam logic [7:0] EV_ALARM_EXT = 8'h0a;
    localparam logic [7:0] EV_THROT_MULTI_DIE = 8'h14;
    localparam logic [7:0] EV_THROT_PKG_MEM = 8'h15;
    localparam logic [7:0] EV_THROT_CORE_TILE = 8'h19;
    localparam logic [7:0] EV_HOT_MULTI_DIE = 8'h1b;
    localparam logic [7:0] EV_HOT_PKG_MEM = 8'h1c;
    localparam logic [7:0] EV_HOT_UNCORE = 8'h1d;
    localparam logic [7:0] EV_HOT_CORE = 8'h1f;
    localparam logic [7:0] EV_PKG_C0 = 8'h2a;
    localparam logic [7:0] EV_PKG_C6 = 8'h2d;
    localparam logic [7:0] EV_MEM_SHED = 8'h2f;
    localparam logic [7:0] EV_OCC_C0 = 8'h35;
    localparam logic [7:0] EV_OCC_C6 = 8'h37;
    localparam logic [7:0] EV_REG_HOT = 8'h42;
    localparam logic [7:0] EV_CORE_TRANS = 8'h72;
    localparam logic [7:0] EV_IO_FLOOR = 8'h73;
    localparam logic [7:0] EV_FREQ_CHANGE = 8'h74;
    localparam logic [7:0] EV_SHED0 = 8'h75;
    localparam logic [7:0] EV_SHED1 = 8'h76;
    localparam logic [7:0] EV_SHED2 = 8'h77;
    localparam logic [7:0] EV_SHED3 = 8'h78;

    // Per-counter control
    typedef struct packed {
        logic enable;
        logic edge_det;
        logic invert;
        logic [OCC_W-1:0] thresh;
        logic [CODE_W-1:0] ev_sel;
    } puecs_ctl_s;

    // Conditions reported by the power controller
    typedef struct packed {
        logic thermal_limit;
        logic throttling;
        logic power_limit;
        logic io_floor;
        logic freq_changing;
        logic [3:0] phase_shed;
        logic core_hot;
        logic package_memory_hot;
        logic multi_die_hot;
        logic uncore_hot;
        logic mem_phase_shed;
        logic pkg_c0;
        logic pkg_c6;
        logic pkg_transition;
        logic [OCC_W-1:0] cores_c0;
        logic [OCC_W-1:0] cores_c6;
        logic alarm_external;
        logic alarm_internal;
        logic throttle_core_tile;
        logic throttle_package_memory;
        logic throttle_multi_die;
        logic core_cstate_trans;
        logic regulator_hot;
    } puecs_cond_s;

    // Decoded event
    typedef struct packed {
        logic valid;
        logic occ;
        logic level;
        logic [OCC_W-1:0] occ_val;
    } puecs_dec_s;

endpackage

// ==== verilog/puecs_ctr_slice.sv ====
// One 48-bit event counter with software load
`timescale 1ns/10ps
module puecs_ctr_slice (
    input wire logic clock,                                  // System clock
    input wire logic resetn,                                 // Sync reset, active low
    input wire logic load,                                   // Software load strobe
    input wire logic [puecs_pkg::CTR_W-1:0] load_data,       // Value to load
    input wire logic [puecs_pkg::OCC_W-1:0] inc,             // Amount to add
    output logic [puecs_pkg::CTR_W-1:0] count                // Counter value
);

    // Accumulate, wrapping at full width; load wins
    always_ff @(posedge clock) begin
        if (!resetn) begin
            count <= puecs_pkg::CTR_RESET;
        end else if (load) begin
            count <= load_data;
        end else begin
            count <= count + puecs_pkg::CTR_W'(inc);
        end
    end

endmodule

// ==== verilog/puecs_top.sv ====
// Event selection and counting for the power controller counters
`timescale 1ns/10ps

// Functional notes
// RL1: Code 0x1 counts every enabled clock
// RL2: Code 0x0 never increments the counter
// RL3: Codes 0x75-0x78 count phase-shed states 0-3
// RL4: Code 0x4 counts thermal frequency throttling
// RL5: Code 0x5 counts power-limited frequency cycles
// RL6: Code 0x73 counts IO floor holding frequency
// RL7: Code 0x74 counts frequency change, unqualified
// RL8: Codes 0x1f,0x1c,0x1b,0x1d count hot conditions
// RL9: Code 0x2f counts memory phase shedding
// RL10: Codes 0x2a/0x2d package residency, transitions excluded
// RL11: Edge counts entrances; edge plus invert, exits
// RL12: Codes 0x35/0x37 give cores in C0/C6
// RL13: Codes 0xa/0x9 count external/internal alarm
// RL14: Codes 0x19,0x15,0x14 count throttling targets
// RL15: Code 0x72 counts core C-state transitions
// RL16: Code 0x42 counts processor regulator hot
// RL17: Four 48-bit counters, each own control
// RL18: Edge detect counts rising transitions
// RL19: Unassigned codes leave counter unchanged
// RL20: Occupancy adds value, or thresholded one
module puecs_top (
    input wire logic clock,                                               // System clock, 20 MHz
    input wire logic resetn,                                              // Sync reset, active low
    input wire puecs_pkg::puecs_cond_s cond,                              // Controller conditions
    input wire puecs_pkg::puecs_ctl_s [puecs_pkg::CTR_NUM-1:0] ctl,       // Counter controls
    input wire logic [puecs_pkg::CTR_NUM-1:0] ctr_load,                   // Counter load strobes
    input wire logic [puecs_pkg::CTR_W-1:0] ctr_load_data,                // Counter load value
    output logic [puecs_pkg::CTR_NUM-1:0][puecs_pkg::CTR_W-1:0] ctr_value, // Counter values
    output logic [puecs_pkg::CTR_NUM-1:0] ctr_active                      // Counted last cycle
);

    // Map an event code onto the condition it watches
    function automatic puecs_pkg::puecs_dec_s decode_event(
        input logic [puecs_pkg::CODE_W-1:0] code,
        input puecs_pkg::puecs_cond_s c
    );
        puecs_pkg::puecs_dec_s d;
        d = '0;
        d.valid = 1'b1;
        case (code)
            puecs_pkg::EV_CLOCKTICKS: d.level = 1'b1; // [RL1]
            puecs_pkg::EV_FREQ_THERMAL: d.level = c.thermal_limit & c.throttling; // [RL4]
            puecs_pkg::EV_FREQ_POWER: d.level = c.power_limit; // [RL5]
            puecs_pkg::EV_IO_FLOOR: d.level = c.io_floor; // [RL6]
            puecs_pkg::EV_FREQ_CHANGE: d.level = c.freq_changing; // [RL7]
            puecs_pkg::EV_SHED0: d.level = c.phase_shed[0]; // [RL3]
            puecs_pkg::EV_SHED1: d.level = c.phase_shed[1]; // [RL3]
            puecs_pkg::EV_SHED2: d.level = c.phase_shed[2]; // [RL3]
            puecs_pkg::EV_SHED3: d.level = c.phase_shed[3]; // [RL3]
            puecs_pkg::EV_HOT_CORE: d.level = c.core_hot; // [RL8]
            puecs_pkg::EV_HOT_PKG_MEM: d.level = c.package_memory_hot; // [RL8]
            puecs_pkg::EV_HOT_MULTI_DIE: d.level = c.multi_die_hot; // [RL8]
            puecs_pkg::EV_HOT_UNCORE: d.level = c.uncore_hot; // [RL8]
            puecs_pkg::EV_MEM_SHED: d.level = c.mem_phase_shed; // [RL9]
            puecs_pkg::EV_PKG_C0: d.level = c.pkg_c0 & ~c.pkg_transition; // [RL10]
            puecs_pkg::EV_PKG_C6: d.level = c.pkg_c6 & ~c.pkg_transition; // [RL10]
            puecs_pkg::EV_OCC_C0: begin // [RL12]
                d.occ = 1'b1;
                d.occ_val = c.cores_c0;
            end
            puecs_pkg::EV_OCC_C6: begin // [RL12]
                d.occ = 1'b1;
                d.occ_val = c.cores_c6;
            end
            puecs_pkg::EV_ALARM_EXT: d.level = c.alarm_external; // [RL13]
            puecs_pkg::EV_ALARM_INT: d.level = c.alarm_internal; // [RL13]
            puecs_pkg::EV_THROT_CORE_TILE: d.level = c.throttle_core_tile; // [RL14]
            puecs_pkg::EV_THROT_PKG_MEM: d.level = c.throttle_package_memory; // [RL14]
            puecs_pkg::EV_THROT_MULTI_DIE: d.level = c.throttle_multi_die; // [RL14]
            puecs_pkg::EV_CORE_TRANS: d.level = c.core_cstate_trans; // [RL15]
            puecs_pkg::EV_REG_HOT: d.level = c.regulator_hot; // [RL16]
            default: d.valid = 1'b0; // [RL2] [RL19]
        endcase
        return d;
    endfunction

    puecs_pkg::puecs_dec_s [puecs_pkg::CTR_NUM-1:0] dec;
    logic [puecs_pkg::CTR_NUM-1:0] lvl;
    logic [puecs_pkg::CTR_NUM-1:0] prev_lvl;
    logic [puecs_pkg::CTR_NUM-1:0] hit;
    logic [puecs_pkg::CTR_NUM-1:0][puecs_pkg::OCC_W-1:0] inc;

    // All checks run on the one clock, quiet during reset
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    genvar i;
    generate
        for (i = 0; i < puecs_pkg::CTR_NUM; i++) begin : g_ctr
            logic thr_on;
            logic occ_add;

            // Decode, threshold and invert the selected event
            assign dec[i] = decode_event(ctl[i].ev_sel, cond);
            assign thr_on = ctl[i].thresh != puecs_pkg::OCC_RESET;
            assign occ_add = dec[i].occ & ~thr_on; // [RL20]
            always_comb begin
                if (!dec[i].valid) begin
                    lvl[i] = 1'b0; // [RL2] [RL19]
                end else if (dec[i].occ) begin
                    lvl[i] = (dec[i].occ_val >= ctl[i].thresh) ^ ctl[i].invert; // [RL20]
                end else begin
                    lvl[i] = dec[i].level ^ ctl[i].invert; // [RL11]
                end
            end

            // Edge detect: count only rising transitions of the level
            assign hit[i] = lvl[i] & (~ctl[i].edge_det | ~prev_lvl[i]); // [RL18] [RL11]

            // Amount added this cycle; nothing while disabled
            always_comb begin
                if (!ctl[i].enable) begin
                    inc[i] = puecs_pkg::OCC_RESET; // [RL1]
                end else if (occ_add) begin
                    inc[i] = dec[i].occ_val; // [RL12] [RL20]
                end else begin
                    inc[i] = {{(puecs_pkg::OCC_W-1){1'b0}}, hit[i]};
                end
            end

            // Previous level for edge detection
            always_ff @(posedge clock) begin
                if (!resetn) begin
                    prev_lvl[i] <= 1'b0;
                end else begin
                    prev_lvl[i] <= lvl[i]; // [RL18]
                end
            end

            // Status: counter advanced on this edge
            always_ff @(posedge clock) begin
                if (!resetn) begin
                    ctr_active[i] <= 1'b0;
                end else begin
                    ctr_active[i] <= ~ctr_load[i] & (inc[i] != puecs_pkg::OCC_RESET);
                end
            end

            // The 48-bit counter itself
            puecs_ctr_slice u_slice (
                .clock(clock),
                .resetn(resetn),
                .load(ctr_load[i]),
                .load_data(ctr_load_data),
                .inc(inc[i]),
                .count(ctr_value[i]) // [RL17]
            );

            // Checks on this counter
            logic plain;
            logic res_c0;
            logic res_c6;
            assign plain = ctl[i].enable & ~ctl[i].edge_det & ~ctl[i].invert & ~ctr_load[i];
            assign res_c0 = cond.pkg_c0 & ~cond.pkg_transition;
            assign res_c6 = cond.pkg_c6 & ~cond.pkg_transition;

            property p_cycle(logic [7:0] code, logic cause);
                plain && ctl[i].ev_sel == code |=> ctr_value[i] == $past(ctr_value[i]) + 48'($past(cause));
            endproperty

            chk_tick_count: assert property ( // [RL1]
                plain && ctl[i].ev_sel == puecs_pkg::EV_CLOCKTICKS ##1 plain && $stable(ctl[i])
                |=> ctr_value[i] == $past(ctr_value[i], 2) + 48'h2)
                else $error("clock tick event did not count every cycle");
            chk_disabled_hold: assert property ( // [RL1]
                !ctl[i].enable && !ctr_load[i] |=> $stable(ctr_value[i]))
                else $error("disabled counter changed");
            chk_none_hold: assert property ( // [RL2]
                ctl[i].ev_sel == puecs_pkg::EV_NONE && !ctr_load[i] |=> $stable(ctr_value[i]))
                else $error("no-event code changed the counter");
            chk_shed_state: assert property ( // [RL3]
                p_cycle(puecs_pkg::EV_SHED2, cond.phase_shed[2]))
                else $error("phase shed state 2 miscounted");
            chk_shed_last: assert property ( // [RL3]
                p_cycle(puecs_pkg::EV_SHED3, cond.phase_shed[3]))
                else $error("phase shed state 3 miscounted");
            chk_thermal_freq: assert property ( // [RL4]
                p_cycle(puecs_pkg::EV_FREQ_THERMAL, cond.thermal_limit && cond.throttling))
                else $error("thermal frequency limit miscounted");
            chk_power_freq: assert property ( // [RL5]
                p_cycle(puecs_pkg::EV_FREQ_POWER, cond.power_limit))
                else $error("power limit miscounted");
            chk_io_floor: assert property ( // [RL6]
                p_cycle(puecs_pkg::EV_IO_FLOOR, cond.io_floor))
                else $error("io floor miscounted");
            chk_freq_change: assert property ( // [RL7]
                p_cycle(puecs_pkg::EV_FREQ_CHANGE, cond.freq_changing))
                else $error("frequency change miscounted");
            chk_hot_multi: assert property ( // [RL8]
                p_cycle(puecs_pkg::EV_HOT_MULTI_DIE, cond.multi_die_hot))
                else $error("multi die hot miscounted");
            chk_hot_memory: assert property ( // [RL8]
                p_cycle(puecs_pkg::EV_HOT_PKG_MEM, cond.package_memory_hot))
                else $error("package memory hot miscounted");
            chk_mem_shed: assert property ( // [RL9]
                p_cycle(puecs_pkg::EV_MEM_SHED, cond.mem_phase_shed))
                else $error("memory phase shedding miscounted");
            chk_pkg_resid: assert property ( // [RL10]
                plain && ctl[i].ev_sel == puecs_pkg::EV_PKG_C6 && cond.pkg_transition
                |=> $stable(ctr_value[i]))
                else $error("transition counted as residency");
            chk_pkg_entry: assert property ( // [RL11]
                ctl[i].enable && ctl[i].edge_det && !ctl[i].invert && !ctr_load[i]
                && ctl[i].ev_sel == puecs_pkg::EV_PKG_C0 && $stable(ctl[i]) && res_c0 && !$past(res_c0)
                |=> ctr_value[i] == $past(ctr_value[i]) + 48'h1)
                else $error("package entrance not counted");
            chk_pkg_exit: assert property ( // [RL11]
                ctl[i].enable && ctl[i].edge_det && ctl[i].invert && !ctr_load[i]
                && ctl[i].ev_sel == puecs_pkg::EV_PKG_C0 && $stable(ctl[i]) && !res_c0 && $past(res_c0)
                |=> ctr_value[i] == $past(ctr_value[i]) + 48'h1)
                else $error("package exit not counted");
            chk_occ_sum: assert property ( // [RL12]
                plain && ctl[i].thresh == 4'h0 && ctl[i].ev_sel == puecs_pkg::EV_OCC_C0
                |=> ctr_value[i] == $past(ctr_value[i]) + 48'($past(cond.cores_c0)))
                else $error("occupancy not accumulated");
            chk_occ_thresh: assert property ( // [RL20]
                plain && ctl[i].thresh != 4'h0 && ctl[i].ev_sel == puecs_pkg::EV_OCC_C6
                |=> ctr_value[i] == $past(ctr_value[i]) + 48'($past(cond.cores_c6) >= $past(ctl[i].thresh)))
                else $error("occupancy threshold miscounted");
            chk_alarm_ext: assert property ( // [RL13]
                p_cycle(puecs_pkg::EV_ALARM_EXT, cond.alarm_external))
                else $error("external alarm miscounted");
            chk_alarm_int: assert property ( // [RL13]
                p_cycle(puecs_pkg::EV_ALARM_INT, cond.alarm_internal))
                else $error("internal alarm miscounted");
            chk_throt_tile: assert property ( // [RL14]
                p_cycle(puecs_pkg::EV_THROT_CORE_TILE, cond.throttle_core_tile))
                else $error("core tile throttle miscounted");
            chk_core_trans: assert property ( // [RL15]
                p_cycle(puecs_pkg::EV_CORE_TRANS, cond.core_cstate_trans))
                else $error("core transition miscounted");
            chk_reg_hot: assert property ( // [RL16]
                p_cycle(puecs_pkg::EV_REG_HOT, cond.regulator_hot))
                else $error("regulator hot miscounted");
            chk_counter_wrap: assert property ( // [RL17]
                plain && ctl[i].ev_sel == puecs_pkg::EV_CLOCKTICKS && &ctr_value[i]
                |=> ctr_value[i] == 48'h0)
                else $error("counter did not wrap at 48 bits");
            chk_edge_rise: assert property ( // [RL18]
                ctl[i].enable && ctl[i].edge_det && !ctl[i].invert && !ctr_load[i] && $past(resetn)
                && ctl[i].ev_sel == puecs_pkg::EV_FREQ_CHANGE && $stable(ctl[i]) && $past(cond.freq_changing)
                |=> $stable(ctr_value[i]))
                else $error("edge detect counted a held level");
            chk_unknown_hold: assert property ( // [RL19]
                ctl[i].ev_sel == 8'h11 && !ctr_load[i] |=> $stable(ctr_value[i]))
                else $error("unassigned code changed the counter");
            chk_load_value: assert property (
                ctr_load[i] |=> ctr_value[i] == $past(ctr_load_data))
                else $error("load value not taken");

            cov_ticks: cover property (plain && ctl[i].ev_sel == puecs_pkg::EV_CLOCKTICKS [*4]);
            cov_entry: cover property (ctl[i].edge_det && ctl[i].ev_sel == puecs_pkg::EV_PKG_C0 && hit[i]);
            cov_occ: cover property (ctl[i].enable && occ_add && dec[i].occ_val > 4'h4);
            cov_thresh: cover property (ctl[i].enable && dec[i].occ && thr_on && hit[i]);
        end
    endgenerate

endmodule

// ==== verif/puecs_tb_top.sv ====
// Self-checking testbench for the power controller event counters
`timescale 1ns/10ps
module puecs_tb_top;
    logic clock;
    logic resetn;
    puecs_pkg::puecs_cond_s cond;
    puecs_pkg::puecs_ctl_s [3:0] ctl, next_ctl;
    logic [3:0] ctr_load, next_load;
    logic [47:0] ctr_load_data, next_data;
    logic [3:0][47:0] ctr_value;
    logic [3:0] ctr_active;
    logic [31:0] seed;
    int error_cnt;
    int n_tests;
    logic [47:0] exp_val [4];
    logic exp_act [4];
    logic skip_act [4];
    logic prev_lvl [4];
    puecs_pkg::puecs_dec_s d;
    logic lvl;
    logic [3:0] inc;
    logic [7:0] codes [38] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h09, 8'h0a, 8'h14, 8'h15, 8'h19, 8'h1b, 8'h1c,
        8'h1d, 8'h1f, 8'h2a, 8'h2d, 8'h2f, 8'h35, 8'h37, 8'h42, 8'h72, 8'h73, 8'h74, 8'h75, 8'h76, 8'h77,
        8'h78, 8'h06, 8'h11, 8'h12, 8'h16, 8'h18, 8'h1e, 8'h30, 8'h49, 8'h4a, 8'h60, 8'h80, 8'hff};

    puecs_top DUT (
        .clock(clock),
        .resetn(resetn),
        .cond(cond),
        .ctl(ctl),
        .ctr_load(ctr_load),
        .ctr_load_data(ctr_load_data),
        .ctr_value(ctr_value),
        .ctr_active(ctr_active)
    );

    // Clock at 20 MHz
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // Xorshift source with fixed start
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Expected event decode from the controller conditions
    function automatic puecs_pkg::puecs_dec_s ev_decode(input logic [7:0] code, input puecs_pkg::puecs_cond_s c);
        puecs_pkg::puecs_dec_s r;
        r = '0;
        r.valid = 1'b1;
        case (code)
            8'h01: r.level = 1'b1;
            8'h04: r.level = c.thermal_limit & c.throttling;
            8'h05: r.level = c.power_limit;
            8'h73: r.level = c.io_floor;
            8'h74: r.level = c.freq_changing;
            8'h75, 8'h76, 8'h77, 8'h78: r.level = c.phase_shed[code - 8'h75];
            8'h1f: r.level = c.core_hot;
            8'h1c: r.level = c.package_memory_hot;
            8'h1b: r.level = c.multi_die_hot;
            8'h1d: r.level = c.uncore_hot;
            8'h2f: r.level = c.mem_phase_shed;
            8'h2a: r.level = c.pkg_c0 & ~c.pkg_transition;
            8'h2d: r.level = c.pkg_c6 & ~c.pkg_transition;
            8'h0a: r.level = c.alarm_external;
            8'h09: r.level = c.alarm_internal;
            8'h19: r.level = c.throttle_core_tile;
            8'h15: r.level = c.throttle_package_memory;
            8'h14: r.level = c.throttle_multi_die;
            8'h72: r.level = c.core_cstate_trans;
            8'h42: r.level = c.regulator_hot;
            8'h35: begin
                r.occ = 1'b1;
                r.occ_val = c.cores_c0;
            end
            8'h37: begin
                r.occ = 1'b1;
                r.occ_val = c.cores_c6;
            end
            default: r.valid = 1'b0;
        endcase
        return r;
    endfunction

    // Reference counters, advanced from the inputs seen at each edge
    always @(posedge clock) begin
        for (int i = 0; i < 4; i++) begin
            d = ev_decode(ctl[i].ev_sel, cond);
            if (d.occ) begin
                lvl = (d.occ_val >= ctl[i].thresh) ^ ctl[i].invert;
            end else begin
                lvl = d.valid & (d.level ^ ctl[i].invert);
            end
            if (d.occ && ctl[i].thresh == 4'h0) begin
                inc = ctl[i].enable ? d.occ_val : 4'h0;
            end else begin
                inc = {3'h0, ctl[i].enable & d.valid & lvl & (~ctl[i].edge_det | ~prev_lvl[i])};
            end
            skip_act[i] = d.occ && ctl[i].thresh == 4'h0 && ctl[i].enable && d.occ_val == 4'h0;
            if (!resetn) begin
                exp_val[i] = 48'h0;
                exp_act[i] = 1'b0;
                prev_lvl[i] = 1'b0;
            end else begin
                if (ctr_load[i]) begin
                    exp_val[i] = ctr_load_data;
                    exp_act[i] = 1'b0;
                end else begin
                    exp_val[i] = exp_val[i] + {44'h0, inc};
                    exp_act[i] = inc != 4'h0;
                end
                prev_lvl[i] = lvl;
            end
        end
    end

    // One comparison, counted and reported
    task automatic check(input string name, input logic [47:0] exp, input logic [47:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Compare every counter at mid-cycle
    always @(negedge clock) begin
        if (resetn === 1'b1) begin
            for (int i = 0; i < 4; i++) begin
                check($sformatf("ctr_value[%0d]", i), exp_val[i], ctr_value[i]);
                if (!skip_act[i]) begin
                    check($sformatf("ctr_active[%0d]", i), {47'h0, exp_act[i]}, {47'h0, ctr_active[i]});
                end
            end
        end
    end

    // One clock of stimulus, cond optionally held
    task automatic step(input logic hold);
        @(posedge clock);
        if (!hold) begin
            cond <= puecs_pkg::puecs_cond_s'(rnd());
        end
        ctl <= next_ctl;
        ctr_load <= next_load;
        ctr_load_data <= next_data;
        next_load = 4'h0;
    endtask

    // Reprogram a counter and reload it in the same cycle
    task automatic set_ctl(input int i, input puecs_pkg::puecs_ctl_s c, input logic [47:0] v);
        next_ctl[i] = c;
        next_load[i] = 1'b1;
        next_data = v;
    endtask

    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Watchdog on the whole run
    initial begin
        repeat (100000) @(posedge clock);
        error_cnt++;
        final_report();
    end

    // Main sequence
    initial begin
        puecs_pkg::puecs_ctl_s c;
        logic [31:0] r;
        seed = 32'h412af270;
        error_cnt = 0;
        n_tests = 0;
        resetn = 1'b0;
        cond = '0;
        ctl = '0;
        next_ctl = '0;
        ctr_load = 4'h0;
        next_load = 4'h0;
        ctr_load_data = 48'h0;
        next_data = 48'h0;
        repeat (16) @(posedge clock);
        resetn <= 1'b1;
        // Each code on counter k % 4 only, plain then with random modifiers
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 38; k++) begin
                r = rnd();
                c = {p == 0 ? 1'b1 : r[0] | r[1], p == 1 && r[2], p == 1 && r[3], r[7:4], codes[k]};
                set_ctl(k % 4, c, {r[15:0], rnd()});
                repeat (6) step(1'b0);
            end
        end
        $display("test code_table done");
        // Slow conditions so edges, exits and thresholds show
        set_ctl(0, {1'b1, 1'b1, 1'b0, 4'h0, 8'h74}, 48'h0);
        set_ctl(1, {1'b1, 1'b1, 1'b1, 4'h0, 8'h2a}, 48'h0);
        set_ctl(2, {1'b1, 1'b1, 1'b0, 4'h0, 8'h2d}, 48'h0);
        set_ctl(3, {1'b1, 1'b1, 1'b0, 4'h5, 8'h35}, 48'h0);
        for (int k = 0; k < 240; k++) begin
            step(k % 5 != 0);
        end
        $display("test edge_detect done");
        // Wrap from all ones, with back-to-back loads before it
        set_ctl(0, {1'b1, 1'b0, 1'b0, 4'h0, 8'h01}, 48'h1234);
        step(1'b0);
        set_ctl(0, {1'b1, 1'b0, 1'b0, 4'h0, 8'h01}, 48'hffffffffffff);
        step(1'b0);
        step(1'b0);
        step(1'b0);
        @(negedge clock);
        check("wrap ctr_value[0]", 48'h0, ctr_value[0]);
        $display("test wrap done");
        // Random programming and conditions
        for (int k = 0; k < 2000; k++) begin
            if (k % 5 == 0) begin
                r = rnd();
                c = {r[0] | r[1], r[2], r[3], r[7:4], r[8] ? r[23:16] : codes[r[15:9] % 38]};
                set_ctl(r[25:24], c, {r, r[15:0]});
            end
            step(1'b0);
        end
        $display("test random done");
        step(1'b0);
        final_report();
    end
endmodule
